// [hw/ppc_pin_cell.v]
// One pad's configuration logic: drive, open-drain, pull-up, TTL, analog.
// Assumes the pad input is already synchronised to i_mclk.
`timescale 1ns/1ps

module ppc_pin_cell #(
   parameter IMPL = 1,
   parameter HAS_DIR = 1,
   parameter HAS_PU = 1,
   parameter HAS_TTL = 0,
   parameter HAS_OD = 0,
   parameter FORCE_OD = 0,
   parameter HAS_ANA = 0
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // Configuration
   input wire i_dir_out,
   input wire i_pu,
   input wire i_ttl,
   input wire i_od,
   input wire i_ana,
   input wire i_dig_en,
   // Output data
   input wire i_port_data,
   input wire i_alt_en,
   input wire i_alt_data,
   // Pad side
   input wire i_pad_in,
   output reg o_pad_out,
   output reg o_pad_oe,
   output reg o_pu_en,
   output reg o_ttl_sel,
   output reg o_ana_sel,
   output reg o_seg_en,
   output reg o_din
);

   wire dig_ok;
   wire drive_on;
   wire is_od;
   wire val;

   // ==========================================================================
   // Digital path gating
   // analog blocks digital
   assign dig_ok = (IMPL != 0) && i_dig_en && !((HAS_ANA != 0) && i_ana);
   assign drive_on = (HAS_DIR != 0) && i_dir_out && dig_ok;
   assign is_od = (FORCE_OD != 0) || ((HAS_OD != 0) && i_od);
   assign val = i_alt_en ? i_alt_data : i_port_data;

   // ==========================================================================
   // Registered pad controls
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pad_out <= 1'b0;
         o_pad_oe <= 1'b0;
         o_pu_en <= 1'b0;
         o_ttl_sel <= 1'b0;
         o_ana_sel <= 1'b0;
         o_seg_en <= 1'b0;
         o_din <= 1'b0;
      end else begin
         o_pad_out <= val && !is_od;
         o_pad_oe <= drive_on && (!is_od || !val);
         o_pu_en <= (HAS_PU != 0) && i_pu && !drive_on && dig_ok;
         o_ttl_sel <= (HAS_TTL != 0) && i_ttl && dig_ok;
         o_ana_sel <= (IMPL != 0) && (HAS_ANA != 0) && i_ana;
         o_seg_en <= (IMPL != 0) && i_dig_en && !((HAS_ANA != 0) && i_ana);
         o_din <= dig_ok && i_pad_in;
      end
   end

endmodule

// [hw/ppc_port_pin_config.v]
// Top of the port pin configuration block: configuration registers,
// redirection of alternate functions, input synchronisers, pin cells.
// Assumes pads resolve level from out/oe/pull-up and software writes via strobes.
`timescale 1ns/1ps
`include "ppc_port_pin_config_regs.vh"

// What this block does
// - Every output-capable pin bit has its own direction setting, independent of neighbours.
// - Per-pin pull-up acts only in input mode, off while driving.
// - Capable input pins can switch to a TTL-threshold input buffer.
// - Capable output pins can become open-drain, never driving high.
// - Both port 6 pins are always open-drain, no pull-up control.
// - Analog select bit per pin blocks digital input and output.
// - Pins reset invalid keep output, input and segment disabled until enabled.
// - Four redirection registers move alternate functions to alternative pins.
// - Small variant port 12: three I/O bits with pull-up, four input-only.
// - Port 13 is one input-only bit feeding external interrupt 0.
// - Port 0 has four bits, two analog (small) or seven, three analog.
module ppc_port_pin_config #(
   parameter SMALL_VARIANT = 1
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rstn,
   // Configuration writes, one strobe per register
   input wire i_dir_we,
   input wire [16:0] i_dir,
   input wire i_pu_we,
   input wire [16:0] i_pu,
   input wire i_ttl_we,
   input wire [16:0] i_ttl,
   input wire i_od_we,
   input wire [16:0] i_od,
   input wire i_ana_we,
   input wire [16:0] i_ana,
   input wire i_dig_en_we,
   input wire [16:0] i_dig_en,
   input wire i_port_out_we,
   input wire [16:0] i_port_out,
   input wire [3:0] i_redir_we,
   input wire [7:0] i_redir,
   // Peripheral side
   input wire [1:0] i_tmr_en,
   input wire [1:0] i_tmr_out,
   input wire [1:0] i_irq_dflt_pin,
   output reg [2:0] o_irq,
   // Pads
   input wire [16:0] i_pad_in,
   output wire [16:0] o_pad_out,
   output wire [16:0] o_pad_oe,
   output wire [16:0] o_pu_en,
   output wire [16:0] o_ttl_sel,
   output wire [16:0] o_ana_sel,
   output wire [16:0] o_seg_en,
   // Readback
   output wire [16:0] o_port_in,
   output wire [16:0] o_dir,
   output wire [16:0] o_pu,
   output wire [16:0] o_ttl,
   output wire [16:0] o_od,
   output wire [16:0] o_ana,
   output wire [16:0] o_dig_en,
   output wire [31:0] o_redir
);

   // ==========================================================================
   // Variant capabilities
   // port 0 width and analog bits
   localparam [16:0] IMPL = SMALL_VARIANT ? `PPC_IMPL_SMALL : `PPC_IMPL_LARGE;
   localparam [16:0] DIRM = SMALL_VARIANT ? `PPC_DIR_SMALL : `PPC_DIR_LARGE;
   localparam [16:0] PUM = SMALL_VARIANT ? `PPC_PU_SMALL : `PPC_PU_LARGE;
   localparam [16:0] TTLM = SMALL_VARIANT ? `PPC_TTL_SMALL : `PPC_TTL_LARGE;
   localparam [16:0] ODM = SMALL_VARIANT ? `PPC_OD_SMALL : `PPC_OD_LARGE;
   localparam [16:0] ANAM = SMALL_VARIANT ? `PPC_ANA_SMALL : `PPC_ANA_LARGE;
   localparam [16:0] INVM = SMALL_VARIANT ? `PPC_INV_SMALL : `PPC_INV_LARGE;
   localparam [16:0] RST_ANA = ANAM;
   localparam [16:0] RST_DIG = IMPL & ~INVM;

   // ==========================================================================
   // Reset release and input synchronisers
   reg rst_s1_r;
   reg rst_n_r;
   reg [16:0] pad_s1_r;
   reg [16:0] pad_s2_r;
   reg [1:0] irq_s1_r;
   reg [1:0] irq_s2_r;

   always @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   always @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pad_s1_r <= 17'h00000;
         pad_s2_r <= 17'h00000;
         irq_s1_r <= 2'h0;
         irq_s2_r <= 2'h0;
      end else begin
         pad_s1_r <= i_pad_in;
         pad_s2_r <= pad_s1_r;
         irq_s1_r <= i_irq_dflt_pin;
         irq_s2_r <= irq_s1_r;
      end
   end

   // ==========================================================================
   // Configuration registers
   reg [16:0] dir_r;
   reg [16:0] pu_r;
   reg [16:0] ttl_r;
   reg [16:0] od_r;
   reg [16:0] ana_r;
   reg [16:0] dig_en_r;
   reg [16:0] port_out_r;
   reg [7:0] redir_r [0:3];
   integer k;

   always @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         dir_r <= `PPC_RST_DIR;
         pu_r <= `PPC_RST_PU;
         ttl_r <= `PPC_RST_TTL;
         od_r <= `PPC_RST_OD;
         ana_r <= RST_ANA;
         dig_en_r <= RST_DIG;
         port_out_r <= `PPC_RST_PORT_OUT;
         for (k = 0; k < 4; k = k + 1) begin
            redir_r[k] <= `PPC_RST_REDIR;
         end
      end else begin
         if (i_dir_we) begin
            dir_r <= i_dir & DIRM;
         end
         // no pull-up bit for port 6
         if (i_pu_we) begin
            pu_r <= i_pu & PUM;
         end
         if (i_ttl_we) begin
            ttl_r <= i_ttl & TTLM;
         end
         if (i_od_we) begin
            od_r <= i_od & ODM;
         end
         if (i_ana_we) begin
            ana_r <= i_ana & ANAM;
         end
         if (i_dig_en_we) begin
            dig_en_r <= i_dig_en & IMPL;
         end
         if (i_port_out_we) begin
            port_out_r <= i_port_out & DIRM;
         end
         for (k = 0; k < 4; k = k + 1) begin
            if (i_redir_we[k]) begin
               redir_r[k] <= i_redir;
            end
         end
      end
   end

   // ==========================================================================
   // Alternate function routing
   wire [4:0] tmr0_pin;
   wire [4:0] tmr1_pin;
   wire [16:0] alt_en;
   wire [16:0] alt_data;
   wire [16:0] din;

   assign tmr0_pin = redir_r[0][`PPC_REDIR_SEL_BIT] ? `PPC_TMR0_ALT_PIN : `PPC_TMR0_DFLT_PIN;
   assign tmr1_pin = redir_r[1][`PPC_REDIR_SEL_BIT] ? `PPC_TMR1_ALT_PIN : `PPC_TMR1_DFLT_PIN;

   always @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_irq <= 3'h0;
      end else begin
         o_irq[0] <= din[`PPC_IDX_P13_7];
         // interrupt inputs moved to port 6
         o_irq[1] <= redir_r[2][`PPC_REDIR_SEL_BIT] ? din[`PPC_IRQ3_ALT_PIN] : irq_s2_r[0];
         o_irq[2] <= redir_r[3][`PPC_REDIR_SEL_BIT] ? din[`PPC_IRQ4_ALT_PIN] : irq_s2_r[1];
      end
   end

   // ==========================================================================
   // Pin cells
   genvar g;
   generate
      for (g = 0; g < `PPC_NPIN; g = g + 1) begin : g_pin
         assign alt_en[g] = (i_tmr_en[0] && (tmr0_pin == g)) ||
                            (i_tmr_en[1] && (tmr1_pin == g));
         assign alt_data[g] = (i_tmr_en[0] && (tmr0_pin == g)) ? i_tmr_out[0] : i_tmr_out[1];
         ppc_pin_cell #(
            .IMPL(IMPL[g]),
            .HAS_DIR(DIRM[g]),
            .HAS_PU(PUM[g]),
            .HAS_TTL(TTLM[g]),
            .HAS_OD(ODM[g]),
            .FORCE_OD(`PPC_FORCE_OD >> g & 1),
            .HAS_ANA(ANAM[g])
         ) u_cell (
            .i_mclk(i_mclk),
            .i_rst_n(rst_n_r),
            .i_dir_out(dir_r[g]),
            .i_pu(pu_r[g]),
            .i_ttl(ttl_r[g]),
            .i_od(od_r[g]),
            .i_ana(ana_r[g]),
            .i_dig_en(dig_en_r[g]),
            .i_port_data(port_out_r[g]),
            .i_alt_en(alt_en[g]),
            .i_alt_data(alt_data[g]),
            .i_pad_in(pad_s2_r[g]),
            .o_pad_out(o_pad_out[g]),
            .o_pad_oe(o_pad_oe[g]),
            .o_pu_en(o_pu_en[g]),
            .o_ttl_sel(o_ttl_sel[g]),
            .o_ana_sel(o_ana_sel[g]),
            .o_seg_en(o_seg_en[g]),
            .o_din(din[g])
         );
      end
   endgenerate

   // ==========================================================================
   // Readback
   assign o_port_in = din;
   assign o_dir = dir_r;
   assign o_pu = pu_r;
   assign o_ttl = ttl_r;
   assign o_od = od_r;
   assign o_ana = ana_r;
   assign o_dig_en = dig_en_r;
   assign o_redir = {redir_r[3], redir_r[2], redir_r[1], redir_r[0]};

endmodule

// [hw/ppc_port_pin_config_regs.vh]
// Constants for the port pin configuration block: pin map, capability masks,
// reset values and redirection bit positions.
// Assumes one flat pin vector: 0-6 port 0 (bits 1-7), 7-8 port 6,
// 9-15 port 12 (bits 1-7), 16 port 13 (bit 7).
`ifndef PPC_PORT_PIN_CONFIG_REGS_VH
`define PPC_PORT_PIN_CONFIG_REGS_VH

// ==========================================================================
// Pin vector layout
`define PPC_NPIN 17
`define PPC_IDX_P6_0 7
`define PPC_IDX_P6_1 8
`define PPC_IDX_P13_7 16

// ==========================================================================
// Capability masks, large variant (seven-bit port 0)
`define PPC_IMPL_LARGE 17'h11fff
`define PPC_DIR_LARGE 17'h001ff
`define PPC_PU_LARGE 17'h0007f
`define PPC_TTL_LARGE 17'h0004c
`define PPC_OD_LARGE 17'h0006e
`define PPC_ANA_LARGE 17'h0001c
`define PPC_INV_LARGE 17'h00000

// ==========================================================================
// Capability masks, small variant (four-bit port 0, port 12 upper bits)
`define PPC_IMPL_SMALL 17'h1fff4
`define PPC_DIR_SMALL 17'h0e1f4
`define PPC_PU_SMALL 17'h0e074
`define PPC_TTL_SMALL 17'h00040
`define PPC_OD_SMALL 17'h00060
`define PPC_ANA_SMALL 17'h00014
`define PPC_INV_SMALL 17'h0e060

// ==========================================================================
// Pins driven as open-drain only (port 6)
`define PPC_FORCE_OD 17'h00180

// ==========================================================================
// Reset values of the configuration registers
`define PPC_RST_DIR 17'h00000
`define PPC_RST_PU 17'h00000
`define PPC_RST_TTL 17'h00000
`define PPC_RST_OD 17'h00000
`define PPC_RST_PORT_OUT 17'h00000
`define PPC_RST_REDIR 8'h00

// ==========================================================================
// Redirection: register k, bit 0 moves function k to its alternative pin
`define PPC_REDIR_SEL_BIT 0
`define PPC_TMR0_DFLT_PIN 5'h04
`define PPC_TMR0_ALT_PIN 5'h0d
`define PPC_TMR1_DFLT_PIN 5'h06
`define PPC_TMR1_ALT_PIN 5'h0e
`define PPC_IRQ3_ALT_PIN 7
`define PPC_IRQ4_ALT_PIN 8

`endif

// [sim/port_pin_config_tb_top.sv]
// Testbench for the port pin configuration block, small variant.
// Assumes the pad model and the bound checker are compiled with it.
`timescale 1ns/1ps

module port_pin_config_tb_top;
   logic i_mclk;
   logic i_rstn;
   logic [16:0] wd;
   logic [6:0] we;
   logic [3:0] i_redir_we;
   logic [1:0] i_tmr_en;
   logic [1:0] i_tmr_out;
   logic [1:0] i_irq_dflt_pin;
   logic [16:0] ext_en;
   logic [16:0] ext_v;
   wire [16:0] i_pad_in, o_pad_out, o_pad_oe, o_pu_en, o_ttl_sel, o_ana_sel, o_seg_en;
   wire [16:0] o_port_in, o_dir, o_pu, o_ttl, o_od, o_ana, o_dig_en;
   wire [31:0] o_redir;
   wire [2:0] o_irq;
   int fail_count = 0;
   int n_checks = 0;

   ppc_port_pin_config #(.SMALL_VARIANT(1)) u_dut (.*, .i_dir_we(we[0]), .i_dir(wd),
      .i_pu_we(we[1]), .i_pu(wd), .i_ttl_we(we[2]), .i_ttl(wd), .i_od_we(we[3]),
      .i_od(wd), .i_ana_we(we[4]), .i_ana(wd), .i_dig_en_we(we[5]), .i_dig_en(wd),
      .i_port_out_we(we[6]), .i_port_out(wd), .i_redir(wd[7:0]));
   ppc_pad_model u_pads (.i_out(o_pad_out), .i_oe(o_pad_oe), .i_pu_en(o_pu_en),
      .i_ext_en(ext_en), .i_ext_val(ext_v), .o_pad(i_pad_in));

   // ======================================================================
   // Shared tasks
   task automatic cyc(input int n);
      repeat (n) @(negedge i_mclk);
   endtask
   // Registers 0-6 are the strobes in we, 7-10 the redirection registers
   task automatic wr(input int k, input logic [16:0] v);
      wd = v;
      if (k < 7) we[k] = 1'b1;
      else i_redir_we[k-7] = 1'b1;
      cyc(1);
      we = '0;
      i_redir_we = '0;
      cyc(3);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic end_sim;
      if (fail_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_reset;
      chk(o_ana, 17'h00014);
      chk(o_ana_sel, 17'h00014);
      chk(o_dig_en, 17'h11f94);
      chk(o_seg_en, 17'h11f80);
      chk(o_pad_oe, 17'h0);
   endtask
   task automatic t_dir;
      wr(0, 17'h1ffff);
      chk(o_dir, 17'h0e1f4);
      wr(0, 17'h00020);
      chk(o_dir, 17'h00020);
   endtask
   task automatic t_pu;
      wr(4, 17'h0);
      wr(5, 17'h1ffff);
      chk(o_dig_en, 17'h1fff4);
      chk(o_seg_en, 17'h1fff4);
      wr(1, 17'h1ffff);
      chk(o_pu, 17'h0e074);
      chk(o_pu_en, 17'h0e054);
      wr(2, 17'h1ffff);
      chk(o_ttl, 17'h00040);
      chk(o_ttl_sel, 17'h00040);
   endtask
   task automatic t_od;
      wr(0, 17'h001e0);
      wr(3, 17'h1ffff);
      chk(o_od, 17'h00060);
      wr(6, 17'h001e0);
      chk(o_pad_oe & 17'h001e0, 17'h0);
      wr(6, 17'h0);
      chk(o_pad_oe & 17'h001e0, 17'h001e0);
      wr(3, 17'h0);
      wr(6, 17'h001e0);
      chk(o_pad_oe & 17'h001e0, 17'h00060);
      chk(o_pad_out & 17'h001e0, 17'h00060);
   endtask
   task automatic t_ana;
      ext_en[2] = 1'b1;
      ext_v[2] = 1'b1;
      cyc(4);
      chk(o_port_in[2], 1'b1);
      wr(4, 17'h1ffff);
      chk(o_ana, 17'h00014);
      chk(o_port_in[2], 1'b0);
      wr(4, 17'h0);
      ext_en[2] = 1'b0;
   endtask
   task automatic t_redir;
      wr(0, 17'h06050);
      wr(3, 17'h00040);
      i_tmr_en = 2'b11;
      i_tmr_out = 2'b11;
      cyc(2);
      chk(o_pad_oe & 17'h06050, 17'h06010);
      chk(o_pad_out & 17'h06050, 17'h00010);
      wr(7, 17'h1);
      wr(8, 17'h1);
      wr(10, 17'ha4);
      chk(o_redir, 32'ha4000101);
      chk(o_pad_oe & 17'h06050, 17'h06010);
      chk(o_pad_out & 17'h06050, 17'h06000);
      i_tmr_en = 2'b00;
   endtask
   task automatic t_irq;
      ext_en[8:7] = 2'b11;
      ext_v[8:7] = 2'b00;
      i_irq_dflt_pin = 2'b11;
      cyc(5);
      chk(o_irq[2:1], 2'b11);
      wr(9, 17'h1);
      chk(o_irq[2:1], 2'b10);
      wr(10, 17'h1);
      chk(o_irq[2:1], 2'b00);
      chk(o_redir, 32'h01010101);
      ext_en[8:7] = 2'b00;
      i_irq_dflt_pin = 2'b00;
   endtask
   task automatic t_p13;
      int i;
      ext_en[16] = 1'b1;
      ext_v[16] = 1'b0;
      i = 0;
      while (o_irq[0] !== 1'b0 && i < 8) begin
         cyc(1);
         i++;
      end
      if (i == 8) begin
         fail_count++;
         $display("ERROR %0t interrupt line stuck", $time);
      end else begin
         chk(o_port_in[16], 1'b0);
         chk(o_pad_oe[16], 1'b0);
         ext_en[16] = 1'b0;
         cyc(5);
         chk(o_irq[0], 1'b1);
      end
   endtask

   // ======================================================================
   // Clock and main sequence
   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   initial begin
      i_rstn = 1'b0;
      wd = '0;
      we = '0;
      i_redir_we = '0;
      i_tmr_en = '0;
      i_tmr_out = '0;
      i_irq_dflt_pin = '0;
      ext_en = '0;
      ext_v = '0;
      cyc(20);
      i_rstn = 1'b1;
      cyc(4);
      t_reset;
      t_dir;
      t_pu;
      t_od;
      t_ana;
      t_redir;
      t_irq;
      t_p13;
      end_sim;
   end
endmodule

// [sim/ppc_pad_model.sv]
// Pad model: resolves each pin level from the block's drive, an outside
// driver and the on-chip pull-up.
// Assumes the bench never drives a pin while the block enables it.
`timescale 1ns/1ps

module ppc_pad_model (
   // Block side
   input wire [16:0] i_out,
   input wire [16:0] i_oe,
   input wire [16:0] i_pu_en,
   // Outside driver
   input wire [16:0] i_ext_en,
   input wire [16:0] i_ext_val,
   // Pin level
   output wire [16:0] o_pad
);
   // ======================================================================
   // Resolution
   // A floating pin without pull-up shows the inverse of the outside driver's value
   assign o_pad = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
      | (~i_oe & ~i_ext_en & (i_pu_en | ~i_ext_val));
endmodule

// [sim/ppc_port_pin_config_props.sv]
// Checker for the port pin configuration block, bound to its top.
// Assumes writes start no earlier than the third edge after reset release.
`timescale 1ns/1ps
`include "ppc_port_pin_config_regs.vh"

module ppc_port_pin_config_chk #(
   parameter SMALL_VARIANT = 1
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rstn,
   // Stimulus
   input wire i_dir_we,
   input wire [16:0] i_dir,
   input wire [3:0] i_redir_we,
   input wire [7:0] i_redir,
   input wire [16:0] i_pad_in,
   // Results
   input wire [16:0] o_pad_out,
   input wire [16:0] o_pad_oe,
   input wire [16:0] o_pu_en,
   input wire [16:0] o_ana_sel,
   input wire [16:0] o_seg_en,
   input wire [16:0] o_port_in,
   input wire [16:0] o_dir,
   input wire [16:0] o_pu,
   input wire [16:0] o_od,
   input wire [16:0] o_ana,
   input wire [16:0] o_dig_en,
   input wire [31:0] o_redir,
   input wire [2:0] o_irq
);
   localparam [16:0] DIRM = SMALL_VARIANT ? `PPC_DIR_SMALL : `PPC_DIR_LARGE;
   localparam [16:0] ANAM = SMALL_VARIANT ? `PPC_ANA_SMALL : `PPC_ANA_LARGE;
   localparam [16:0] DENM = SMALL_VARIANT ? (`PPC_IMPL_SMALL & ~`PPC_INV_SMALL)
      : (`PPC_IMPL_LARGE & ~`PPC_INV_LARGE);

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   // ======================================================================
   // Sequences
   sequence p13_chg;
      $changed(i_pad_in[16]) ##4 1'b1;
   endsequence
   sequence redir0_wr;
      i_redir_we[0] ##1 1'b1;
   endsequence

   // ======================================================================
   // Assertions
   od_no_high_a: assert property ((o_pad_oe & o_pad_out & $past(o_od)) == 17'h0)
      else $error("open-drain pin driven high");
   p6_od_a: assert property ((o_pad_oe[8:7] & o_pad_out[8:7]) == 2'b00
      && o_pu[8:7] == 2'b00) else $error("port 6 pin not open-drain");
   pu_input_a: assert property ((o_pu_en & $past(o_dir)) == 17'h0)
      else $error("pull-up on an output pin");
   ana_block_a: assert property (((o_pad_oe | o_seg_en | o_port_in) & o_ana_sel) == 17'h0)
      else $error("digital path open on analog pin");
   inval_off_a: assert property (((o_seg_en | o_pad_oe | o_pu_en) & ~$past(o_dig_en))
      == 17'h0) else $error("invalid pin not disabled");
   dir_take_a: assert property (i_dir_we |=> o_dir == ($past(i_dir) & DIRM))
      else $error("direction write wrong");
   dir_mask_a: assert property ((o_dir & ~DIRM) == 17'h0 && o_pu[16] == 1'b0)
      else $error("input-only pin got direction or pull-up");
   reset_val_a: assert property ($rose(i_rstn) |-> o_ana == ANAM && o_dig_en == DENM)
      else $error("reset pin state wrong");
   redir_take_a: assert property (redir0_wr |-> o_redir[7:0] == $past(i_redir))
      else $error("redirection write wrong");
   irq0_track_a: assert property (p13_chg |-> o_irq[0] == $past(i_pad_in[16], 4))
      else $error("interrupt 0 does not follow pin");
endmodule

bind ppc_port_pin_config ppc_port_pin_config_chk #(.SMALL_VARIANT(SMALL_VARIANT)) u_chk (.*);
